/* File: rtl/hsp_pkg.sv */
// Purpose: constants and types for the host serial port pin block.
// Assumes: 20 MHz system clock samples every pin through two flip-flops.
// Notes: serial frame is 1 read bit, 7 address bits, 8 data bits.
package hsp_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned STRAP_HOLD_US = 2000;
   // Straps are caught once they have been steady after reset release
   localparam int unsigned STRAP_CYCLES = STRAP_HOLD_US * (CLK_HZ / 1000000);
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam logic [3:0] CMD_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'hF;
   localparam logic [3:0] I2C_BASE_ADDR = 4'hA;
   localparam logic [1:0] MODE_RESET = 2'h0;
   typedef enum logic [1:0] {
      HSP_I2C_SLAVE = 2'b00,
      HSP_SPI = 2'b01,
      HSP_UART = 2'b10,
      HSP_I2C_MASTER = 2'b11
   } hsp_mode_e;
   typedef enum logic [1:0] {
      HSP_IDLE = 2'b00,
      HSP_CMD = 2'b01,
      HSP_DATA = 2'b10,
      HSP_DONE = 2'b11
   } hsp_state_e;
endpackage : hsp_pkg

/* File: rtl/hsp_reg_if.sv */
// Purpose: register access path between pin logic and serial engine.
// Assumes: one clock domain.
// Notes: write and read are one-cycle strobes.
`timescale 1ns/1ps
interface hsp_reg_if;
   import hsp_pkg::*;
   logic wr;
   logic rd;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   modport pins (output wr, output rd, output addr, output wdata,
      input rdata);
   modport regs (input wr, input rd, input addr, input wdata,
      output rdata);
endinterface : hsp_reg_if

/* File: rtl/hsp_spi_engine.sv */
// Purpose: serial shift engine framed by chip select.
// Assumes: inputs already synchronised; edge pulses from the top.
// Notes: frame is read flag, address, then data, most significant first.
`timescale 1ns/1ps
module hsp_spi_engine
   import hsp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_en,
   input wire logic i_cs_b,
   input wire logic i_rise,
   input wire logic i_fall,
   input wire logic i_sdi,
   input wire logic i_edge_sel,
   hsp_reg_if.pins bus,
   output logic o_sdo,
   output logic o_sdo_oe
);
   hsp_state_e state;
   logic [3:0] cnt;
   logic [DATA_W-1:0] sh;
   logic rd_op;
   logic upd;

   assign upd = i_edge_sel ? i_fall : i_rise;

   // ==================================================
   // Frame control
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= HSP_IDLE;
         cnt <= 4'h0;
         rd_op <= 1'b0;
      end else if (!i_en || i_cs_b) begin
         // Aborted frames are simply dropped; no partial write happens
         state <= HSP_IDLE;
         cnt <= 4'h0;
      end else if (i_rise) begin
         cnt <= cnt + 4'h1;
         if (state == HSP_IDLE) begin
            rd_op <= i_sdi;
            state <= HSP_CMD;
         end else if (state == HSP_CMD && cnt == CMD_BITS - 4'h1) begin
            state <= HSP_DATA;
         end else if (state == HSP_DATA && cnt == LAST_BIT) begin
            state <= HSP_DONE;
         end
      end
   end

   // ==================================================
   // Shift path and register strobes
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sh <= 8'h00;
         bus.addr <= 7'h00;
         bus.wdata <= 8'h00;
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
      end else begin
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         if (i_en && !i_cs_b && i_rise) begin
            if (state == HSP_CMD) begin
               bus.addr <= {bus.addr[ADDR_W-2:0], i_sdi};
               bus.rd <= rd_op && cnt == CMD_BITS - 4'h1;
            end else if (state == HSP_DATA) begin
               sh <= {sh[DATA_W-2:0], i_sdi};
               if (cnt == LAST_BIT && !rd_op) begin
                  bus.wdata <= {sh[DATA_W-2:0], i_sdi};
                  bus.wr <= 1'b1;
               end
            end
         end
      end
   end

   // ==================================================
   // Read data out
   logic [DATA_W-1:0] tx;
   logic loaded;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx <= 8'h00;
         o_sdo <= 1'b0;
         o_sdo_oe <= 1'b0;
         loaded <= 1'b0;
      end else if (!i_en || i_cs_b || !rd_op || state == HSP_IDLE) begin
         o_sdo_oe <= 1'b0;
         o_sdo <= 1'b0;
         loaded <= 1'b0;
      end else if (bus.rd) begin
         tx <= bus.rdata;
         loaded <= 1'b1;
      end else if (loaded && upd && state != HSP_CMD) begin
         o_sdo <= tx[DATA_W-1];
         tx <= {tx[DATA_W-2:0], 1'b0};
         o_sdo_oe <= state == HSP_DATA;
      end
   end
endmodule : hsp_spi_engine

/* File: rtl/hsp_host_port.sv */
// Purpose: host serial port pin block with mode straps and a small
//    register file reached over the shift interface.
// Assumes: host keeps chip select low across each frame.
// Notes: I2C and UART protocol engines sit elsewhere; this block routes
//    their pins and supplies the I2C address.
`timescale 1ns/1ps
module hsp_host_port
   import hsp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [1:0] i_host_port_mode_straps,
   input wire logic i_sclk,
   input wire logic i_sdi,
   input wire logic i_output_edge_select,
   input wire logic i_cs_b,
   input wire logic i_sdo_in,
   input wire logic i_uart_tx,
   input wire logic i_i2c_sda_drive_low,
   output logic o_sdo,
   output logic o_sdo_oe,
   output logic [1:0] o_host_port_select_field,
   output logic [6:0] o_i2c_slave_addr,
   output logic o_i2c_scl,
   output logic o_i2c_sda,
   output logic o_uart_rx
);
   import hsp_pkg::*;

   // ==================================================
   // Pin synchronisers
   logic [1:0] s_sclk, s_sdi, s_edge, s_cs, s_sda;
   logic [1:0] s_mode;
   logic [1:0] m_mode;
   logic sclk_d;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_sclk <= 2'h0;
         s_sdi <= 2'h0;
         s_edge <= 2'h0;
         s_cs <= 2'h3;
         s_sda <= 2'h3;
         m_mode <= 2'h0;
         s_mode <= 2'h0;
         sclk_d <= 1'b0;
      end else begin
         s_sclk <= {s_sclk[0], i_sclk};
         s_sdi <= {s_sdi[0], i_sdi};
         s_edge <= {s_edge[0], i_output_edge_select};
         s_cs <= {s_cs[0], i_cs_b};
         s_sda <= {s_sda[0], i_sdo_in};
         m_mode <= i_host_port_mode_straps;
         s_mode <= m_mode;
         sclk_d <= s_sclk[1];
      end
   end

   // ==================================================
   // Strap capture after reset release
   // Straps must be steady for the hold time, so sample at its end
   logic [15:0] strap_cnt;
   logic strap_done;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         strap_cnt <= 16'h0000;
         strap_done <= 1'b0;
         o_host_port_select_field <= MODE_RESET;
      end else if (!strap_done) begin
         strap_cnt <= strap_cnt + 16'h0001;
         if (strap_cnt == 16'(STRAP_CYCLES - 1)) begin
            strap_done <= 1'b1;
            o_host_port_select_field <= s_mode;
         end
      end
   end

   hsp_mode_e mode;
   assign mode = hsp_mode_e'(o_host_port_select_field);

   // ==================================================
   // I2C and UART pin routing
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_i2c_slave_addr <= 7'h00;
         o_i2c_scl <= 1'b1;
         o_i2c_sda <= 1'b1;
         o_uart_rx <= 1'b1;
      end else begin
         // Address bits 2:0 from the shared pins
         o_i2c_slave_addr <= {I2C_BASE_ADDR, s_sdi[1], s_edge[1],
            s_cs[1]};
         o_i2c_scl <= s_sclk[1];
         o_i2c_sda <= s_sda[1];
         o_uart_rx <= (mode == HSP_UART) ? s_sdi[1] : 1'b1;
      end
   end

   // ==================================================
   // Register file behind the shift interface
   hsp_reg_if rif ();
   logic [DATA_W-1:0] regs [0:3];
   logic spi_sdo, spi_oe;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < 4; i++) begin
            regs[i] <= 8'h00;
         end
      end else if (rif.wr) begin
         regs[rif.addr[1:0]] <= rif.wdata;
      end
   end
   // Address 0 reads back the selected mode; others are scratch
   assign rif.rdata = (rif.addr[1:0] == 2'h0) ?
      {6'h00, o_host_port_select_field} : regs[rif.addr[1:0]];

   hsp_spi_engine u_spi (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_en(strap_done && mode == HSP_SPI),
      .i_cs_b(s_cs[1]),
      .i_rise(s_sclk[1] && !sclk_d),
      .i_fall(!s_sclk[1] && sclk_d),
      .i_sdi(s_sdi[1]),
      .i_edge_sel(s_edge[1]),
      .bus(rif.pins),
      .o_sdo(spi_sdo),
      .o_sdo_oe(spi_oe)
   );

   // ==================================================
   // Shared output pin
   always_comb begin
      o_sdo = 1'b0;
      o_sdo_oe = 1'b0;
      if (mode == HSP_SPI) begin
         o_sdo = spi_sdo;
         o_sdo_oe = spi_oe;
      end else if (mode == HSP_UART) begin
         o_sdo = i_uart_tx;
         o_sdo_oe = 1'b1;
      end else if (mode == HSP_I2C_SLAVE) begin
         o_sdo_oe = i_i2c_sda_drive_low;
      end
   end
endmodule : hsp_host_port

/* File: sim/hsp_host_port_props.sv */
// Purpose: pin checks for the host serial port
// Assumes: straps steady while latched
// Notes: pin paths lag inputs by about three clocks
`timescale 1ns/1ps
module hsp_host_port_props
   import hsp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [1:0] i_host_port_mode_straps,
   input wire logic i_sclk,
   input wire logic i_sdi,
   input wire logic i_output_edge_select,
   input wire logic i_cs_b,
   input wire logic i_sdo_in,
   input wire logic o_sdo,
   input wire logic o_sdo_oe,
   input wire logic [1:0] o_host_port_select_field,
   input wire logic [6:0] o_i2c_slave_addr,
   input wire logic o_i2c_scl,
   input wire logic o_i2c_sda,
   input wire logic o_uart_rx
);
   wire [1:0] m = o_host_port_select_field;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // ==========
   // Checks
   a_strap_latch: assert property ($changed(m) |->
      m == i_host_port_mode_straps) else $error("strap latch");
   a_sdo_edge: assert property ((m == 2'h1 && !i_cs_b && o_sdo_oe &&
      i_sclk == i_output_edge_select)[*3] |-> $stable(o_sdo))
      else $error("sdo moved on wrong edge");
   a_sdo_idle: assert property ((m == 2'h1 && i_cs_b)[*5] |->
      !o_sdo_oe) else $error("sdo driven outside frame");
   a_i2c_addr: assert property ((m == 2'h0 &&
      $stable({i_sdi, i_output_edge_select, i_cs_b}))[*6] |->
      o_i2c_slave_addr == {I2C_BASE_ADDR, i_sdi, i_output_edge_select,
      i_cs_b}) else $error("slave address");
   a_scl_in: assert property ((m == 2'h0 && $stable(i_sclk))[*4] |->
      o_i2c_scl == i_sclk) else $error("scl path");
   a_sda_in: assert property ((m == 2'h0 && $stable(i_sdo_in))[*4] |->
      o_i2c_sda == i_sdo_in) else $error("sda path");
   a_sda_od: assert property (m == 2'h0 && o_sdo_oe |-> !o_sdo)
      else $error("sda driven high");
   a_uart_rx: assert property (m != 2'h2 |-> o_uart_rx)
      else $error("rx not idle");
   a_uart_path: assert property ((m == 2'h2 && $stable(i_sdi))[*4] |->
      o_uart_rx == i_sdi) else $error("rx path");
   a_uart_drive: assert property (m == 2'h2 |-> o_sdo_oe)
      else $error("tx not driven");
   c_read: cover property (m == 2'h1 && $rose(o_sdo_oe));
   c_abort: cover property (m == 2'h1 && $rose(i_cs_b));
   c_pull: cover property (m == 2'h0 && o_sdo_oe);
   c_uart: cover property (m == 2'h2 && !o_uart_rx);
endmodule : hsp_host_port_props

/* File: sim/hsp_host_model.sv */
// Purpose: host shift master for the pin bench
// Assumes: shift clock half period is 4 system clocks
// Notes: clock and data rest low between frames, as the pulls do
`timescale 1ns/1ps
module hsp_host_model (
   input wire logic i_clk,
   input wire logic i_sdo,
   input wire logic i_sdo_oe,
   output logic o_sclk,
   output logic o_sdi,
   output logic o_cs_b
);
   initial begin
      o_sclk = 1'h0;
      o_sdi = 1'h0;
      o_cs_b = 1'h1;
   end
   // ==========
   // Frame
   // Data read at the edge opposite the update edge: half a period
   // of settling covers the pin latency
   task automatic frame(input logic [15:0] w, input int n,
      input logic es, output logic [7:0] r, output logic bad);
      r = 8'h00;
      bad = 1'h0;
      o_cs_b <= 1'h0;
      for (int i = 0; i < n; i++) begin
         o_sdi <= w[15 - i];
         for (int h = 0; h < 2; h++) begin
            repeat (4) @(posedge i_clk);
            if (i > 7 && h != es) begin
               r = {r[6:0], i_sdo};
               bad |= i_sdo_oe !== w[15];
            end
            o_sclk <= (h == 0);
         end
      end
      repeat (4) @(posedge i_clk);
      o_cs_b <= 1'h1;
      o_sdi <= 1'h0;
      repeat (8) @(posedge i_clk);
   endtask : frame
   // Static pin levels for the address strap and routing scenarios
   task automatic park(input logic sclk, input logic sdi,
      input logic cs_b);
      o_sclk <= sclk;
      o_sdi <= sdi;
      o_cs_b <= cs_b;
   endtask : park
endmodule : hsp_host_model

/* File: sim/hsp_host_port_test.sv */
// Purpose: bench for the host serial port pin block
// Assumes: one strap latch per reset, so two resets
// Notes: I2C pins checked before the strap latch, UART routing after it
`timescale 1ns/1ps
module hsp_host_port_test;
   import hsp_pkg::*;
   logic i_clk, i_rst_b, i_output_edge_select, i_uart_tx;
   logic i_i2c_sda_drive_low, sda_host;
   logic [1:0] i_host_port_mode_straps;
   wire i_sclk, i_sdi, i_cs_b, i_sdo_in, o_sdo, o_sdo_oe;
   wire o_i2c_scl, o_i2c_sda, o_uart_rx;
   wire [1:0] o_host_port_select_field;
   wire [6:0] o_i2c_slave_addr;
   int fails = 0;
   int n_tests = 0;
   // Pull-up pin: the host may only pull it low
   assign i_sdo_in = (o_sdo_oe ? o_sdo : 1'h1) & sda_host;
   hsp_host_port DUT (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_host_port_mode_straps(i_host_port_mode_straps),
      .i_sclk(i_sclk),
      .i_sdi(i_sdi),
      .i_output_edge_select(i_output_edge_select),
      .i_cs_b(i_cs_b),
      .i_sdo_in(i_sdo_in),
      .i_uart_tx(i_uart_tx),
      .i_i2c_sda_drive_low(i_i2c_sda_drive_low),
      .o_sdo(o_sdo),
      .o_sdo_oe(o_sdo_oe),
      .o_host_port_select_field(o_host_port_select_field),
      .o_i2c_slave_addr(o_i2c_slave_addr),
      .o_i2c_scl(o_i2c_scl),
      .o_i2c_sda(o_i2c_sda),
      .o_uart_rx(o_uart_rx)
   );
   hsp_host_model hm (.i_clk(i_clk), .i_sdo(i_sdo_in), .i_sdo_oe(o_sdo_oe),
      .o_sclk(i_sclk), .o_sdi(i_sdi), .o_cs_b(i_cs_b));
   initial begin
      i_clk = 1'h0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize;
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
   endtask : wt
   task automatic boot(input logic [1:0] s);
      i_rst_b <= 1'h0;
      i_host_port_mode_straps <= s;
      wt(5);
      i_rst_b <= 1'h1;
   endtask : boot
   task automatic latch(input logic [1:0] s);
      wt(STRAP_CYCLES + 20);
      chk({6'h00, o_host_port_select_field}, {6'h00, s});
   endtask : latch
   task automatic xfer(input logic [15:0] w, input int n, input logic es,
      input logic [7:0] exp);
      logic [7:0] r;
      logic bad;
      i_output_edge_select <= es;
      wt(4);
      hm.frame(w, n, es, r, bad);
      chk({7'h00, bad}, 8'h00);
      if (w[15])
         chk(r, exp);
   endtask : xfer
   // ==========
   // Scenarios
   task automatic t_spi;
      boot(2'h1);
      latch(2'h1);
      xfer(16'h01A5, 16, 1'h1, 8'h00);
      xfer(16'h8100, 16, 1'h1, 8'hA5);
      xfer(16'h023C, 16, 1'h0, 8'h00);
      xfer(16'h8200, 16, 1'h0, 8'h3C);
      xfer(16'h015A, 12, 1'h0, 8'h00);
      xfer(16'h8100, 16, 1'h0, 8'hA5);
      xfer(16'h8000, 16, 1'h1, 8'h01);
   endtask : t_spi
   task automatic t_i2c;
      logic [2:0] p;
      // Field reads I2C slave until the UART straps are latched
      boot(2'h2);
      chk({6'h00, o_host_port_select_field}, {6'h00, MODE_RESET});
      for (int k = 0; k < 2; k++) begin
         p = k ? 3'h2 : 3'h5;
         hm.park(p[0], p[2], p[0]);
         i_output_edge_select <= p[1];
         wt(8);
         chk({1'h0, o_i2c_slave_addr}, {1'h0, I2C_BASE_ADDR, p});
         chk({7'h00, o_i2c_scl}, {7'h00, p[0]});
      end
      i_i2c_sda_drive_low <= 1'h1;
      wt(8);
      chk({5'h00, o_sdo_oe, o_sdo, o_i2c_sda}, 8'h04);
      i_i2c_sda_drive_low <= 1'h0;
      sda_host <= 1'h0;
      wt(8);
      chk({5'h00, o_sdo_oe, o_i2c_sda, o_uart_rx}, 8'h01);
   endtask : t_i2c
   task automatic t_uart;
      latch(2'h2);
      for (int k = 0; k < 2; k++) begin
         hm.park(1'h0, k[0], 1'h1);
         i_uart_tx <= !k[0];
         wt(8);
         chk({6'h00, o_uart_rx, o_sdo}, {6'h00, k[0], !k[0]});
         chk({7'h00, o_sdo_oe}, 8'h01);
      end
   endtask : t_uart
   initial begin
      i_rst_b = 1'h0;
      i_host_port_mode_straps = 2'h1;
      i_output_edge_select = 1'h0;
      i_uart_tx = 1'h1;
      i_i2c_sda_drive_low = 1'h0;
      sda_host = 1'h1;
      t_spi();
      t_i2c();
      t_uart();
      summarize();
   end
   initial begin
      // Two strap waits dominate the run
      wt(2 * STRAP_CYCLES + 5000);
      fails++;
      summarize();
   end
endmodule : hsp_host_port_test
bind hsp_host_port hsp_host_port_props u_props (
   .i_clk(i_clk),
   .i_rst_b(i_rst_b),
   .i_host_port_mode_straps(i_host_port_mode_straps),
   .i_sclk(i_sclk),
   .i_sdi(i_sdi),
   .i_output_edge_select(i_output_edge_select),
   .i_cs_b(i_cs_b),
   .i_sdo_in(i_sdo_in),
   .o_sdo(o_sdo),
   .o_sdo_oe(o_sdo_oe),
   .o_host_port_select_field(o_host_port_select_field),
   .o_i2c_slave_addr(o_i2c_slave_addr),
   .o_i2c_scl(o_i2c_scl),
   .o_i2c_sda(o_i2c_sda),
   .o_uart_rx(o_uart_rx)
);
